// file: uopl_pkg.sv
// Constants, register map and types of the USB line and power control block
package uopl_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register byte addresses
	localparam logic [7:0] ADDR_LINE_CTRL = 8'h00;
	localparam logic [7:0] ADDR_PWR_CTRL = 8'h04;
	localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h08;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h0C;
	localparam logic [7:0] ADDR_INT_CLEAR = 8'h10;
	localparam logic [7:0] ADDR_INT_ENABLE = 8'h14;

	////////////////////////////////////////////////////////////////////////
	// Line control field positions
	localparam int LC_DPLUS_PU = 7;
	localparam int LC_DMINUS_PU = 6;
	localparam int LC_DPLUS_PD = 5;
	localparam int LC_DMINUS_PD = 4;
	localparam int LC_BUS_POWER = 3;
	localparam int LC_SW_CTRL = 2;
	localparam int LC_CHARGE = 1;
	localparam int LC_DISCHARGE = 0;

	// Power control field positions
	localparam int PC_ACT_PEND = 7;
	localparam int PC_SLEEP_GUARD = 4;
	localparam int PC_BUSY = 3;
	localparam int PC_SUSPEND = 1;
	localparam int PC_POWER = 0;
	localparam logic [7:0] PC_WR_MASK = 8'h13;

	// Interrupt flag field positions
	localparam int FL_STALL = 7;
	localparam int FL_ATTACH = 6;
	localparam int FL_RESUME = 5;
	localparam int FL_IDLE = 4;
	localparam int FL_TOKEN = 3;
	localparam int FL_FRAME = 2;
	localparam int FL_ERROR = 1;
	localparam int FL_RESET = 0;
	localparam logic [7:0] FL_W1C_MASK = 8'hFD;

	// Block interrupt status bits
	localparam int IS_ACTIVITY = 0;
	localparam int IS_READY = 1;
	localparam int IS_FLAG = 2;
	localparam int IS_W = 3;

	////////////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [7:0] LINE_CTRL_RST = 8'h00;
	localparam logic [7:0] PWR_CTRL_RST = 8'h00;
	localparam logic [7:0] IRQ_FLAGS_RST = 8'h00;
	localparam logic [IS_W-1:0] INT_RST = 3'h0;
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_NS = 200;
	localparam logic [3:0] SETTLE_CYCLES = 4'((SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam int SYNC_W = 1;

	typedef enum logic [2:0] {
		PWR_OFF = 3'b001,
		PWR_ON = 3'b010,
		PWR_SETTLE = 3'b100
	} uopl_pwr_e;

endpackage

// file: uopl_sync2.sv
// Two flip-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module uopl_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic meta_r;
			logic hold_r;
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					meta_r <= 1'b0;
					hold_r <= 1'b0;
				end else begin
					meta_r <= async_in[i];
					hold_r <= meta_r;
				end
			end
			assign sync_out[i] = hold_r;
		end
	endgenerate

endmodule

// file: uopl_top.sv
// USB line resistor, bus power and module power control with interrupt flags
`timescale 1ns/1ps

// What this block does
// - Software D+ pull-up bit drives D+ pull-up
// - Software D- pull-up bit drives D- pull-up
// - Software D+ pull-down bit drives D+ pull-down
// - Software D- pull-down bit drives D- pull-down
// - Bus power bit requests bus power
// - Software control bit selects software or hardware resistors
// - Charge bit connects bus charge resistor
// - Discharge bit connects bus discharge resistor
// - Activity pending until its interrupt is generated
// - Guard bit blocks sleep on activity, pending activity or any set interrupt flag
// - Busy while on or still settling after off
// - Suspend gates USB clock, transceiver low power
// - Power bit off holds resistor, bus supply, USB clock and low power outputs inactive
// - Hardware sets flags, software writes one clears; error flag only follows its event
// - Flag zero is bus reset or detach
module uopl_top (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rdata,
	input wire logic hw_dplus_pullup,
	input wire logic hw_dminus_pullup,
	input wire logic hw_dplus_pulldown,
	input wire logic hw_dminus_pulldown,
	input wire logic host_mode,
	input wire logic ev_stall,
	input wire logic ev_attach,
	input wire logic ev_resume,
	input wire logic ev_idle,
	input wire logic ev_token_done,
	input wire logic ev_frame_start,
	input wire logic ev_error,
	input wire logic ev_bus_reset,
	input wire logic ev_detach,
	input wire logic bus_activity,
	output logic dplus_pullup_en,
	output logic dminus_pullup_en,
	output logic dplus_pulldown_en,
	output logic dminus_pulldown_en,
	output logic bus_power_on,
	output logic bus_charge_en,
	output logic bus_discharge_en,
	output logic usb_clk_en,
	output logic xcvr_low_power,
	output logic module_on,
	output logic module_busy,
	output logic sleep_block,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// Input synchroniser and edge detect
	logic [uopl_pkg::SYNC_W-1:0] act_sync;
	logic act_s;
	logic act_prev_r;
	logic act_edge;

	uopl_sync2 #(.WIDTH(uopl_pkg::SYNC_W)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.async_in(bus_activity),
		.sync_out(act_sync)
	);

	assign act_s = act_sync[0];
	assign act_edge = act_s & ~act_prev_r;

	////////////////////////////////////////////////////////////////////////
	// State declarations
	uopl_pkg::uopl_pwr_e state_r, state_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic [7:0] line_r, line_nxt;
	logic [7:0] pwr_r, pwr_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [uopl_pkg::IS_W-1:0] ist_r, ist_nxt;
	logic [uopl_pkg::IS_W-1:0] ien_r, ien_nxt;
	logic pend_r, pend_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [7:0] flag_set;
	logic [uopl_pkg::IS_W-1:0] int_ev;
	logic wr_ok;
	logic on_nxt;
	logic susp_nxt;
	logic ready_ev;
	logic act_ev;
	default clocking cb_sys @(posedge clock); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Power state machine
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		ready_ev = 1'b0;
		case (state_r)
			uopl_pkg::PWR_OFF: begin
				if (pwr_nxt[uopl_pkg::PC_POWER]) begin
					state_nxt = uopl_pkg::PWR_ON;
				end
			end
			uopl_pkg::PWR_ON: begin
				if (!pwr_nxt[uopl_pkg::PC_POWER]) begin
					state_nxt = uopl_pkg::PWR_SETTLE;
					cnt_nxt = uopl_pkg::SETTLE_CYCLES - 4'h1;
				end
			end
			uopl_pkg::PWR_SETTLE: begin
				// Enable is only taken from the off state once settled
				if (cnt_r == 4'h0) begin
					state_nxt = uopl_pkg::PWR_OFF;
					ready_ev = 1'b1;
				end else begin
					cnt_nxt = cnt_r - 4'h1;
				end
			end
			default: begin
				state_nxt = uopl_pkg::PWR_OFF;
			end
		endcase
	end

	assign on_nxt = (state_nxt == uopl_pkg::PWR_ON);
	assign susp_nxt = pwr_nxt[uopl_pkg::PC_SUSPEND];

	////////////////////////////////////////////////////////////////////////
	// Register writes, flags and events
	always_comb begin
		// Only power control is writable while settling after disable
		wr_ok = wr_en & (state_r != uopl_pkg::PWR_SETTLE);
		line_nxt = line_r;
		pwr_nxt = pwr_r;
		ien_nxt = ien_r;
		if (wr_en && addr == uopl_pkg::ADDR_PWR_CTRL) begin
			pwr_nxt = wdata[7:0] & uopl_pkg::PC_WR_MASK;
		end else if (wr_ok && addr == uopl_pkg::ADDR_LINE_CTRL) begin
			line_nxt = wdata[7:0];
		end else if (wr_ok && addr == uopl_pkg::ADDR_INT_ENABLE) begin
			ien_nxt = wdata[uopl_pkg::IS_W-1:0];
		end
		flag_set = 8'h00;
		if (state_r == uopl_pkg::PWR_ON) begin
			flag_set[uopl_pkg::FL_STALL] = ev_stall;
			flag_set[uopl_pkg::FL_ATTACH] = ev_attach;
			flag_set[uopl_pkg::FL_RESUME] = ev_resume;
			flag_set[uopl_pkg::FL_IDLE] = ev_idle;
			flag_set[uopl_pkg::FL_TOKEN] = ev_token_done;
			flag_set[uopl_pkg::FL_FRAME] = ev_frame_start;
			flag_set[uopl_pkg::FL_RESET] = host_mode ? ev_detach : ev_bus_reset;
		end
		flags_nxt = flags_r;
		if (wr_ok && addr == uopl_pkg::ADDR_IRQ_FLAGS) begin
			flags_nxt = flags_r & ~(wdata[7:0] & uopl_pkg::FL_W1C_MASK);
		end
		flags_nxt = flags_nxt | flag_set;
		flags_nxt[uopl_pkg::FL_ERROR] = (state_r == uopl_pkg::PWR_ON) & ev_error;
		// Activity waits while the USB clock is gated
		pend_nxt = on_nxt & susp_nxt & (pend_r | act_edge);
		act_ev = (pend_r | (act_edge & on_nxt)) & ~susp_nxt;
		int_ev = 3'h0;
		int_ev[uopl_pkg::IS_ACTIVITY] = act_ev;
		int_ev[uopl_pkg::IS_READY] = ready_ev;
		int_ev[uopl_pkg::IS_FLAG] = |flag_set;
		ist_nxt = ist_r;
		if (wr_ok && addr == uopl_pkg::ADDR_INT_CLEAR) begin
			ist_nxt = ist_r & ~wdata[uopl_pkg::IS_W-1:0];
		end
		ist_nxt = ist_nxt | int_ev;
	end

	////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the strobe
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (rd_en) begin
			if (addr == uopl_pkg::ADDR_LINE_CTRL) begin
				rdata_nxt = {24'h00_0000, line_r};
			end else if (addr == uopl_pkg::ADDR_PWR_CTRL) begin
				rdata_nxt = {24'h00_0000, pend_r, 2'h0, pwr_r[uopl_pkg::PC_SLEEP_GUARD],
					module_busy, 1'h0, pwr_r[uopl_pkg::PC_SUSPEND], pwr_r[uopl_pkg::PC_POWER]};
			end else if (addr == uopl_pkg::ADDR_IRQ_FLAGS) begin
				rdata_nxt = {24'h00_0000, flags_r};
			end else if (addr == uopl_pkg::ADDR_INT_STATUS) begin
				rdata_nxt = {29'h0000_0000, ist_r};
			end else if (addr == uopl_pkg::ADDR_INT_ENABLE) begin
				rdata_nxt = {29'h0000_0000, ien_r};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= uopl_pkg::PWR_OFF;
			cnt_r <= uopl_pkg::CNT_RST;
			line_r <= uopl_pkg::LINE_CTRL_RST;
			pwr_r <= uopl_pkg::PWR_CTRL_RST;
			flags_r <= uopl_pkg::IRQ_FLAGS_RST;
			ist_r <= uopl_pkg::INT_RST;
			ien_r <= uopl_pkg::INT_RST;
			pend_r <= 1'b0;
			act_prev_r <= 1'b0;
			rdata_r <= uopl_pkg::RDATA_RST;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			line_r <= line_nxt;
			pwr_r <= pwr_nxt;
			flags_r <= flags_nxt;
			ist_r <= ist_nxt;
			ien_r <= ien_nxt;
			pend_r <= pend_nxt;
			act_prev_r <= act_s;
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// Registered outputs
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			dplus_pullup_en <= 1'b0;
			dminus_pullup_en <= 1'b0;
			dplus_pulldown_en <= 1'b0;
			dminus_pulldown_en <= 1'b0;
			bus_power_on <= 1'b0;
			bus_charge_en <= 1'b0;
			bus_discharge_en <= 1'b0;
			usb_clk_en <= 1'b0;
			xcvr_low_power <= 1'b0;
			module_on <= 1'b0;
			module_busy <= 1'b0;
			sleep_block <= 1'b0;
			irq <= 1'b0;
		end else begin
			dplus_pullup_en <= on_nxt & (line_nxt[uopl_pkg::LC_SW_CTRL] ?
				line_nxt[uopl_pkg::LC_DPLUS_PU] : hw_dplus_pullup);
			dminus_pullup_en <= on_nxt & (line_nxt[uopl_pkg::LC_SW_CTRL] ?
				line_nxt[uopl_pkg::LC_DMINUS_PU] : hw_dminus_pullup);
			dplus_pulldown_en <= on_nxt & (line_nxt[uopl_pkg::LC_SW_CTRL] ?
				line_nxt[uopl_pkg::LC_DPLUS_PD] : hw_dplus_pulldown);
			dminus_pulldown_en <= on_nxt & (line_nxt[uopl_pkg::LC_SW_CTRL] ?
				line_nxt[uopl_pkg::LC_DMINUS_PD] : hw_dminus_pulldown);
			bus_power_on <= on_nxt & line_nxt[uopl_pkg::LC_BUS_POWER];
			bus_charge_en <= on_nxt & line_nxt[uopl_pkg::LC_CHARGE];
			bus_discharge_en <= on_nxt & line_nxt[uopl_pkg::LC_DISCHARGE];
			usb_clk_en <= on_nxt & ~susp_nxt;
			xcvr_low_power <= on_nxt & susp_nxt;
			module_on <= on_nxt;
			module_busy <= (state_nxt != uopl_pkg::PWR_OFF);
			sleep_block <= pwr_nxt[uopl_pkg::PC_SLEEP_GUARD] & (act_s | pend_nxt | (|flags_nxt));
			irq <= |(ist_nxt & ien_nxt);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions
	property p_dplus_pu;
		(module_on && line_r[uopl_pkg::LC_SW_CTRL]) |-> dplus_pullup_en == line_r[uopl_pkg::LC_DPLUS_PU];
	endproperty
	a_dplus_pu: assert property (p_dplus_pu) else $error("D+ pull-up does not follow its bit");
	property p_dminus_pu;
		(module_on && line_r[uopl_pkg::LC_SW_CTRL]) |-> dminus_pullup_en == line_r[uopl_pkg::LC_DMINUS_PU];
	endproperty
	a_dminus_pu: assert property (p_dminus_pu) else $error("D- pull-up does not follow its bit");
	property p_dplus_pd;
		(module_on && line_r[uopl_pkg::LC_SW_CTRL]) |-> dplus_pulldown_en == line_r[uopl_pkg::LC_DPLUS_PD];
	endproperty
	a_dplus_pd: assert property (p_dplus_pd) else $error("D+ pull-down does not follow its bit");
	property p_dminus_pd;
		(module_on && line_r[uopl_pkg::LC_SW_CTRL]) |-> dminus_pulldown_en == line_r[uopl_pkg::LC_DMINUS_PD];
	endproperty
	a_dminus_pd: assert property (p_dminus_pd) else $error("D- pull-down does not follow its bit");
	property p_bus_supply;
		module_on |-> (bus_power_on == line_r[uopl_pkg::LC_BUS_POWER]) && (bus_charge_en == line_r[uopl_pkg::LC_CHARGE])
			&& (bus_discharge_en == line_r[uopl_pkg::LC_DISCHARGE]);
	endproperty
	a_bus_supply: assert property (p_bus_supply) else $error("Bus supply controls do not follow their bits");
	property p_hw_ctrl;
		(module_on && !line_r[uopl_pkg::LC_SW_CTRL]) |-> {dplus_pullup_en, dminus_pullup_en, dplus_pulldown_en,
			dminus_pulldown_en} == {$past(hw_dplus_pullup), $past(hw_dminus_pullup), $past(hw_dplus_pulldown),
			$past(hw_dminus_pulldown)};
	endproperty
	a_hw_ctrl: assert property (p_hw_ctrl) else $error("Hardware resistor control not applied");
	property p_pend;
		($fell(pend_r) && module_on) |-> ist_r[uopl_pkg::IS_ACTIVITY];
	endproperty
	a_pend: assert property (p_pend) else $error("Pending activity not raised on resume");
	property p_guard;
		!pwr_r[uopl_pkg::PC_SLEEP_GUARD] |-> !sleep_block;
	endproperty
	a_guard: assert property (p_guard) else $error("Sleep blocked without guard");
	sequence s_disable;
		module_on ##1 !module_on;
	endsequence
	property p_busy_settle;
		s_disable |-> module_busy ##[8:11] !module_busy;
	endproperty
	a_busy_settle: assert property (p_busy_settle) else $error("Busy does not settle after disable");
	property p_suspend;
		module_on |-> (usb_clk_en != pwr_r[uopl_pkg::PC_SUSPEND]) && (xcvr_low_power == pwr_r[uopl_pkg::PC_SUSPEND]);
	endproperty
	a_suspend: assert property (p_suspend) else $error("Suspend does not gate clock");
	property p_off_quiet;
		!module_on |-> !(dplus_pullup_en || dminus_pullup_en || dplus_pulldown_en || dminus_pulldown_en
			|| bus_power_on || bus_charge_en || bus_discharge_en || usb_clk_en);
	endproperty
	a_off_quiet: assert property (p_off_quiet) else $error("Outputs active while disabled");
	property p_settle_lock;
		(state_r == uopl_pkg::PWR_SETTLE && wr_en && addr == uopl_pkg::ADDR_LINE_CTRL) |=> $stable(line_r);
	endproperty
	a_settle_lock: assert property (p_settle_lock) else $error("Write taken while settling");
	property p_error_flag;
		flags_r[uopl_pkg::FL_ERROR] == ($past(ev_error) && ($past(state_r) == uopl_pkg::PWR_ON));
	endproperty
	a_error_flag: assert property (p_error_flag) else $error("Error flag not read-only follower");
	property p_set_wins;
		(state_r == uopl_pkg::PWR_ON && ev_stall) |=> flags_r[uopl_pkg::FL_STALL];
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("Stall flag event lost");
	property p_detach;
		(state_r == uopl_pkg::PWR_ON && host_mode && ev_detach) |=> flags_r[uopl_pkg::FL_RESET];
	endproperty
	a_detach: assert property (p_detach) else $error("Detach not flagged in host mode");
endmodule

// file: uopl_cable_model.sv
// Cable side model: bursts of bus activity seen through the transceiver
`timescale 1ns/1ps
module uopl_cable_model #(
	parameter int LAG_NS = 7,
	parameter int HOLD_NS = 130
) (
	input wire logic burst_req,
	output logic bus_activity
);
	initial bus_activity = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// Burst unrelated in phase to the system clock, line idles low after
	always @(posedge burst_req) begin
		#(LAG_NS) bus_activity = 1'b1;
		#(HOLD_NS) bus_activity = 1'b0;
	end
endmodule

// file: tb.sv
// Self-checking bench for the USB line and power control block
`timescale 1ns/1ps
module tb;
	logic clock, rst_n, wr_en, rd_en, host_mode, ev_err, ev_det, burst_req, bus_activity;
	logic [7:0] addr, ev;
	logic [31:0] wdata, rdata;
	logic [3:0] hw;
	logic dpu, dmu, dpd, dmd, bpo, chg, dis, clk_en, low_pwr, on, busy, slp, irq;
	logic [7:0] lines;
	int fail_count, total_checks, n;

	assign lines = {dpu, dmu, dpd, dmd, bpo, 1'b0, chg, dis};

	uopl_top uopl_top_i (.clock(clock), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .hw_dplus_pullup(hw[3]), .hw_dminus_pullup(hw[2]),
		.hw_dplus_pulldown(hw[1]), .hw_dminus_pulldown(hw[0]), .host_mode(host_mode), .ev_stall(ev[7]),
		.ev_attach(ev[6]), .ev_resume(ev[5]), .ev_idle(ev[4]), .ev_token_done(ev[3]),
		.ev_frame_start(ev[2]), .ev_error(ev_err), .ev_bus_reset(ev[0]), .ev_detach(ev_det),
		.bus_activity(bus_activity), .dplus_pullup_en(dpu), .dminus_pullup_en(dmu),
		.dplus_pulldown_en(dpd), .dminus_pulldown_en(dmd), .bus_power_on(bpo), .bus_charge_en(chg),
		.bus_discharge_en(dis), .usb_clk_en(clk_en), .xcvr_low_power(low_pwr), .module_on(on),
		.module_busy(busy), .sleep_block(slp), .irq(irq));

	uopl_cable_model uopl_cable_model_i (.burst_req(burst_req), .bus_activity(bus_activity));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////
	// Compare, bus and event tasks
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic cmp1(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clock);
		wr_en <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clock);
		rd_en <= 1'b0;
		#1;
		cmp32(rdata, exp, "read");
	endtask

	task automatic pulse(input logic [7:0] v, input logic det);
		@(posedge clock);
		ev <= v;
		ev_det <= det;
		@(posedge clock);
		ev <= 8'h00;
		ev_det <= 1'b0;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_n = 1'b0;
		{addr, wdata, wr_en, rd_en, hw, host_mode, ev, ev_err, ev_det, burst_req} = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (20) @(posedge clock);
		cmp32({19'h0, lines, on, busy, clk_en, low_pwr, irq}, 32'h0, "reset outputs");
		rst_n <= 1'b1;
		rd(uopl_pkg::ADDR_LINE_CTRL, 32'h0);
		rd(uopl_pkg::ADDR_PWR_CTRL, 32'h0);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h0);
		wr(8'h20, 32'hFF);
		rd(8'h20, 32'h0);
		wr(uopl_pkg::ADDR_PWR_CTRL, 32'h1);
		cmp1(on, 1'b1, "on");
		cmp1(busy, 1'b1, "busy when on");
		cmp1(clk_en, 1'b1, "clock runs");
		for (int i = 0; i < 8; i++) begin
			if (i != 2) begin
				wr(uopl_pkg::ADDR_LINE_CTRL, 32'h4 | (32'h1 << i));
				cmp32({24'h0, lines}, 32'h1 << i, "line out");
			end
		end
		wr(uopl_pkg::ADDR_LINE_CTRL, 32'hF4);
		cmp32({24'h0, lines}, 32'hF0, "sw resistors");
		rd(uopl_pkg::ADDR_LINE_CTRL, 32'hF4);
		wr(uopl_pkg::ADDR_LINE_CTRL, 32'hF0);
		foreach (lines[i]) begin
			if (i < 4) begin
				hw <= 4'h1 << i;
				repeat (2) @(posedge clock);
				#1;
				cmp32({24'h0, lines}, 32'h10 << i, "hw resistors");
			end
		end
		pulse(8'hFD, 1'b0);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'hFD);
		ev_err <= 1'b1;
		repeat (2) @(posedge clock);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'hFF);
		wr(uopl_pkg::ADDR_IRQ_FLAGS, 32'h00);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'hFF);
		wr(uopl_pkg::ADDR_IRQ_FLAGS, 32'hF0);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h0F);
		wr(uopl_pkg::ADDR_IRQ_FLAGS, 32'hFF);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h02);
		ev_err <= 1'b0;
		repeat (2) @(posedge clock);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h0);
		host_mode <= 1'b1;
		pulse(8'h01, 1'b0);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h0);
		pulse(8'h00, 1'b1);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h1);
		wr(uopl_pkg::ADDR_IRQ_FLAGS, 32'h1);
		host_mode <= 1'b0;
		pulse(8'h00, 1'b1);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h0);
		rd(uopl_pkg::ADDR_INT_STATUS, 32'h4);
		cmp1(irq, 1'b0, "irq masked");
		wr(uopl_pkg::ADDR_INT_ENABLE, 32'h4);
		cmp1(irq, 1'b1, "irq raised");
		wr(uopl_pkg::ADDR_INT_CLEAR, 32'h4);
		cmp1(irq, 1'b0, "irq cleared");
		rd(uopl_pkg::ADDR_INT_STATUS, 32'h0);
		wr(uopl_pkg::ADDR_PWR_CTRL, 32'h13);
		cmp1(clk_en, 1'b0, "clock gated");
		cmp1(low_pwr, 1'b1, "low power");
		burst_req <= 1'b1;
		repeat (8) @(posedge clock);
		burst_req <= 1'b0;
		rd(uopl_pkg::ADDR_PWR_CTRL, 32'h9B);
		cmp1(slp, 1'b1, "sleep blocked");
		rd(uopl_pkg::ADDR_INT_STATUS, 32'h0);
		wr(uopl_pkg::ADDR_PWR_CTRL, 32'h11);
		repeat (3) @(posedge clock);
		rd(uopl_pkg::ADDR_PWR_CTRL, 32'h19);
		rd(uopl_pkg::ADDR_INT_STATUS, 32'h1);
		cmp1(slp, 1'b0, "sleep free");
		wr(uopl_pkg::ADDR_INT_ENABLE, 32'h1);
		cmp1(irq, 1'b1, "activity irq");
		wr(uopl_pkg::ADDR_INT_CLEAR, 32'h1);
		wr(uopl_pkg::ADDR_PWR_CTRL, 32'h1);
		burst_req <= 1'b1;
		repeat (4) @(posedge clock);
		#1;
		cmp1(slp, 1'b0, "no guard");
		burst_req <= 1'b0;
		rd(uopl_pkg::ADDR_INT_STATUS, 32'h1);
		wr(uopl_pkg::ADDR_INT_CLEAR, 32'h1);
		hw <= 4'hF;
		wr(uopl_pkg::ADDR_LINE_CTRL, 32'h0B);
		cmp32({24'h0, lines}, 32'hFB, "before off");
		wr(uopl_pkg::ADDR_PWR_CTRL, 32'h0);
		cmp32({22'h0, lines, on, clk_en}, 32'h0, "held inactive");
		n = 0;
		// No register writes until busy drops
		while (busy === 1'b1 && n < 50) begin
			n++;
			@(posedge clock);
			#1;
		end
		cmp32(32'(n), 32'(uopl_pkg::SETTLE_CYCLES), "busy span");
		rd(uopl_pkg::ADDR_INT_STATUS, 32'h2);
		pulse(8'hFD, 1'b0);
		rd(uopl_pkg::ADDR_IRQ_FLAGS, 32'h0);
		wr(uopl_pkg::ADDR_PWR_CTRL, 32'h1);
		cmp1(on, 1'b1, "back on");
		end_sim();
	end
endmodule
